// file: rtl/mior_dev.sv
// Flash device end of the multi-I/O read: decodes the opcode, takes the
// address, counts mode and dummy cycles and drives read data.
// Assumes the SPI clock comes from the host and is sampled on i_sys_clk.
// Function
// RL1: Quad I/O read uses opcode EBh.
// RL2: Quad I/O: two mode, four dummy.
// RL3: Quad Out uses opcode 6Bh.
// RL4: Quad Out: no mode, eight dummy.
// RL5: Dual Out uses opcode 3Bh.
// RL6: Dual Out: no mode, eight dummy.
// RL7: Dual I/O uses opcode BBh.
// RL8: Dual I/O timing follows latency table.
// RL9: Dual I/O timing byte 04h or 80h.
// RL10: Timing byte packs mode high, dummy low.
// RL11: Quad I/O timing byte 44h at 08h.
// RL12: Host releases lines during dummy cycles.
`timescale 1ns/100ps
module mior_dev
  import mior_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  mior_if.dev bus,
  input wire logic i_enh_lat,
  input wire logic [7:0] i_rd_data,
  input wire logic [7:0] i_disc_ofs,
  output logic [7:0] o_disc_byte,
  output logic o_busy,
  output logic [23:0] o_addr,
  output logic o_addr_valid
);

  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DATA} mior_dst_t;

  mior_dst_t st_q;
  logic [2:0] sck_s_q;
  logic [2:0] cs_s_q;
  logic [3:0] io1_q;
  logic [3:0] io2_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_hi;
  logic [7:0] sh_q;
  logic [5:0] cnt_q;
  logic [1:0] width_q;
  logic [1:0] awidth_q;
  logic [2:0] mode_n_q;
  logic [4:0] dummy_n_q;
  logic [7:0] dsh_q;
  logic [1:0] dcnt_q;
  logic [3:0] dout_q;
  logic [3:0] doe_n_q;

  mior_timing_rom u_rom (
    .i_ofs(i_disc_ofs),
    .i_enh_lat(i_enh_lat),
    .o_byte(o_disc_byte)
  );

  // Three-stage SCK and CS_N synchronisers, two-stage io; edges use stages two and three
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      sck_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      io1_q <= 4'h0;
      io2_q <= 4'h0;
    end
    else
    begin
      sck_s_q <= {sck_s_q[1:0], bus.sck};
      cs_s_q <= {cs_s_q[1:0], bus.cs_n};
      io1_q <= bus.io_in;
      io2_q <= io1_q;
    end
  end

  assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
  assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
  assign cs_hi = cs_s_q[1] & cs_s_q[2];
  assign o_busy = (st_q != S_IDLE);

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [1:0] w,
                                          input logic [3:0] d);
    logic [7:0] r;
    r = v;
    if (w == 2'h2)
      r = {v[3:0], d};
    else if (w == 2'h1)
      r = {v[5:0], d[1:0]};
    else
      r = {v[6:0], d[0]};
    shift_in = r;
  endfunction

  function automatic logic [5:0] bits_per(input logic [1:0] w, input logic [5:0] n);
    bits_per = (w == 2'h2) ? {2'h0, n[5:2]} : (w == 2'h1) ? {1'h0, n[5:1]} : n;
  endfunction

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || cs_hi)
    begin
      st_q <= S_IDLE;
      cnt_q <= 6'h0;
      sh_q <= 8'h0;
      width_q <= 2'h0;
      awidth_q <= 2'h0;
      mode_n_q <= 3'h0;
      dummy_n_q <= 5'h0;
      o_addr <= 24'h0;
      o_addr_valid <= 1'b0;
    end
    else
    begin
      o_addr_valid <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          st_q <= S_OPC;
          cnt_q <= 6'h0;
        end
        S_OPC:
          if (sck_rise)
          begin
            sh_q <= {sh_q[6:0], io2_q[0]};
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == 6'h7)
            begin
              cnt_q <= 6'h0;
              st_q <= S_ADDR;
              case ({sh_q[6:0], io2_q[0]})
                MIOR_OP_QUAD_IO:
                begin
                  awidth_q <= 2'h2; // see RL1
                  width_q <= 2'h2;
                  mode_n_q <= MIOR_QIO_MODE; // see RL2
                  dummy_n_q <= MIOR_QIO_DUMMY;
                end
                MIOR_OP_QUAD_OUT:
                begin
                  awidth_q <= 2'h0; // see RL3
                  width_q <= 2'h2;
                  mode_n_q <= MIOR_QOUT_MODE; // see RL4
                  dummy_n_q <= MIOR_QOUT_DUMMY;
                end
                MIOR_OP_DUAL_OUT:
                begin
                  awidth_q <= 2'h0; // see RL5
                  width_q <= 2'h1;
                  mode_n_q <= MIOR_DOUT_MODE; // see RL6
                  dummy_n_q <= MIOR_DOUT_DUMMY;
                end
                MIOR_OP_DUAL_IO:
                begin
                  awidth_q <= 2'h1; // see RL7
                  width_q <= 2'h1;
                  mode_n_q <= i_enh_lat ? MIOR_DIO_MODE_ENH : MIOR_DIO_MODE_STD; // see RL8
                  dummy_n_q <= i_enh_lat ? MIOR_DIO_DUMMY_ENH : MIOR_DIO_DUMMY_STD;
                end
                default:
                  st_q <= S_IDLE;
              endcase
            end
          end
        S_ADDR:
          if (sck_rise)
          begin
            o_addr <= (awidth_q == 2'h2) ? {o_addr[19:0], io2_q} :
                      (awidth_q == 2'h1) ? {o_addr[21:0], io2_q[1:0]} :
                      {o_addr[22:0], io2_q[0]};
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == bits_per(awidth_q, 6'(MIOR_ADDR_BITS)) - 6'h1)
            begin
              cnt_q <= 6'h0;
              o_addr_valid <= 1'b1;
              st_q <= (mode_n_q != 3'h0) ? S_MODE :
                      (dummy_n_q != 5'h0) ? S_DUMMY : S_DATA;
            end
          end
        S_MODE:
          if (sck_rise)
          begin
            cnt_q <= cnt_q + 6'h1;
            // Data starts one SCK early: the pin synchroniser delays every edge
            if (dummy_n_q == 5'h0 && cnt_q == {3'h0, mode_n_q} - 6'h2)
            begin
              cnt_q <= 6'h0;
              st_q <= S_DATA;
            end
            else if (cnt_q == {3'h0, mode_n_q} - 6'h1)
            begin
              cnt_q <= 6'h0;
              st_q <= S_DUMMY;
            end
          end
        S_DUMMY:
          if (sck_rise)
          begin
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == {1'h0, dummy_n_q} - 6'h2)
            begin
              cnt_q <= 6'h0;
              st_q <= S_DATA;
            end
          end
        S_DATA:
          st_q <= S_DATA;
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // Read data shifts out on falling SCK, width set by the command
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || cs_hi || st_q != S_DATA)
    begin
      dsh_q <= i_rd_data;
      dcnt_q <= 2'h0;
      dout_q <= 4'h0;
      doe_n_q <= 4'hF;
    end
    else if (sck_fall)
    begin
      dcnt_q <= dcnt_q + 2'h1;
      if (width_q == 2'h2)
      begin
        dout_q <= dsh_q[7:4];
        dsh_q <= {dsh_q[3:0], 4'h0};
        doe_n_q <= 4'h0;
      end
      else
      begin
        dout_q <= {2'h0, dsh_q[7:6]};
        dsh_q <= {dsh_q[5:0], 2'h0};
        doe_n_q <= 4'hC;
      end
      // Last unit of the byte: fetch the next byte
      if ((width_q == 2'h2 && dcnt_q[0]) || dcnt_q == 2'h3)
      begin
        dcnt_q <= 2'h0;
        dsh_q <= i_rd_data;
      end
    end
  end

  assign bus.d_io_out = dout_q;
  assign bus.d_io_oe_n = doe_n_q;

endmodule

// file: rtl/mior_pkg.sv
// Package for the multi-I/O read framing: opcodes, mode and dummy cycle
// counts, and the discovery-table offsets and packing of those counts.
// Assumes a single system clock shared by both ends.
package mior_pkg;

  localparam logic [7:0] MIOR_OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] MIOR_OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] MIOR_OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] MIOR_OP_DUAL_IO = 8'hBB;

  localparam logic [2:0] MIOR_QIO_MODE = 3'h2;
  localparam logic [4:0] MIOR_QIO_DUMMY = 5'h04;
  localparam logic [2:0] MIOR_QOUT_MODE = 3'h0;
  localparam logic [4:0] MIOR_QOUT_DUMMY = 5'h08;
  localparam logic [2:0] MIOR_DOUT_MODE = 3'h0;
  localparam logic [4:0] MIOR_DOUT_DUMMY = 5'h08;
  localparam logic [2:0] MIOR_DIO_MODE_ENH = 3'h4;
  localparam logic [4:0] MIOR_DIO_DUMMY_ENH = 5'h00;
  localparam logic [2:0] MIOR_DIO_MODE_STD = 3'h0;
  localparam logic [4:0] MIOR_DIO_DUMMY_STD = 5'h04;

  // Timing byte layout: mode count in 7:5, dummy count in 4:0
  localparam int MIOR_TB_MODE_LSB = 5;
  localparam int MIOR_TB_DUMMY_LSB = 0;

  // Relative byte offsets of the discovery parameter (timing, opcode pairs)
  localparam logic [7:0] MIOR_OFS_QIO_TIM = 8'h08;
  localparam logic [7:0] MIOR_OFS_QIO_OP = 8'h09;
  localparam logic [7:0] MIOR_OFS_QOUT_TIM = 8'h0A;
  localparam logic [7:0] MIOR_OFS_QOUT_OP = 8'h0B;
  localparam logic [7:0] MIOR_OFS_DOUT_TIM = 8'h0C;
  localparam logic [7:0] MIOR_OFS_DOUT_OP = 8'h0D;
  localparam logic [7:0] MIOR_OFS_DIO_TIM = 8'h0E;
  localparam logic [7:0] MIOR_OFS_DIO_OP = 8'h0F;
  localparam logic [7:0] MIOR_UNMAPPED = 8'hFF;

  // Address bits sent in a read
  localparam int MIOR_ADDR_BITS = 24;

  typedef enum logic [1:0] {MIOR_CMD_QIO, MIOR_CMD_QOUT, MIOR_CMD_DOUT, MIOR_CMD_DIO} mior_cmd_t;

  function automatic logic [7:0] mior_pack(input logic [2:0] mode, input logic [4:0] dummy);
    mior_pack = {mode, dummy};
  endfunction

endpackage

// file: rtl/mior_if.sv
// Interface joining the SPI host end and the flash device end.
// Assumes the testbench resolves io lines from the output enables.
`timescale 1ns/100ps
interface mior_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_out;
  logic [3:0] h_io_oe_n;
  logic [3:0] d_io_out;
  logic [3:0] d_io_oe_n;
  logic [3:0] io_in;

  modport host (output sck, output cs_n, output h_io_out, output h_io_oe_n, input io_in);
  modport dev (input sck, input cs_n, output d_io_out, output d_io_oe_n, input io_in);
endinterface

// file: rtl/mior_timing_rom.sv
// Discovery timing table lookup: returns one byte for a relative offset.
// Assumes the offset is stable while it is read.
`timescale 1ns/100ps
module mior_timing_rom
  import mior_pkg::*;
(
  input wire logic [7:0] i_ofs,
  input wire logic i_enh_lat,
  output logic [7:0] o_byte
);

  always_comb
  begin
    if (i_ofs == MIOR_OFS_QIO_TIM)
      o_byte = mior_pack(MIOR_QIO_MODE, MIOR_QIO_DUMMY); // see RL10 RL11
    else if (i_ofs == MIOR_OFS_QIO_OP)
      o_byte = MIOR_OP_QUAD_IO;
    else if (i_ofs == MIOR_OFS_QOUT_TIM)
      o_byte = mior_pack(MIOR_QOUT_MODE, MIOR_QOUT_DUMMY); // see RL10
    else if (i_ofs == MIOR_OFS_QOUT_OP)
      o_byte = MIOR_OP_QUAD_OUT;
    else if (i_ofs == MIOR_OFS_DOUT_TIM)
      o_byte = mior_pack(MIOR_DOUT_MODE, MIOR_DOUT_DUMMY);
    else if (i_ofs == MIOR_OFS_DOUT_OP)
      o_byte = MIOR_OP_DUAL_OUT;
    else if (i_ofs == MIOR_OFS_DIO_TIM)
      o_byte = i_enh_lat ? mior_pack(MIOR_DIO_MODE_ENH, MIOR_DIO_DUMMY_ENH)
                         : mior_pack(MIOR_DIO_MODE_STD, MIOR_DIO_DUMMY_STD); // see RL9
    else if (i_ofs == MIOR_OFS_DIO_OP)
      o_byte = MIOR_OP_DUAL_IO;
    else
      o_byte = MIOR_UNMAPPED;
  end

endmodule

// file: rtl/mior_host.sv
// Host end: issues one multi-I/O read with the framing for its command.
// Assumes the device end decodes on the same system clock.
`timescale 1ns/100ps
module mior_host
  import mior_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  mior_if.host bus,
  input wire logic i_start,
  input wire mior_cmd_t i_cmd,
  input wire logic i_enh_lat,
  input wire logic [23:0] i_addr,
  input wire logic i_stop,
  output logic o_ready,
  output logic [7:0] o_data,
  output logic o_data_valid
);

  typedef enum logic [2:0] {H_IDLE, H_OPC, H_ADDR, H_MODE, H_DUMMY, H_DATA} mior_hst_t;

  mior_hst_t st_q;
  logic sck_q;
  logic [31:0] sh_q;
  logic [5:0] cnt_q;
  logic [1:0] aw_q;
  logic [1:0] dw_q;
  logic [2:0] mode_q;
  logic [4:0] dummy_q;
  logic [7:0] rx_q;
  logic [3:0] oe_n_q;

  assign o_ready = (st_q == H_IDLE);
  assign bus.sck = sck_q;
  assign bus.cs_n = (st_q == H_IDLE);
  assign bus.h_io_out = (aw_q == 2'h2 && st_q != H_OPC) ? sh_q[31:28] :
                        (aw_q == 2'h1 && st_q != H_OPC) ? {2'h0, sh_q[31:30]} :
                        {3'h0, sh_q[31]};
  assign bus.h_io_oe_n = oe_n_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      st_q <= H_IDLE;
      sck_q <= 1'b0;
      sh_q <= 32'h0;
      cnt_q <= 6'h0;
      aw_q <= 2'h0;
      dw_q <= 2'h0;
      mode_q <= 3'h0;
      dummy_q <= 5'h0;
      rx_q <= 8'h0;
      oe_n_q <= 4'hF;
      o_data <= 8'h0;
      o_data_valid <= 1'b0;
    end
    else
    begin
      o_data_valid <= 1'b0;
      if (st_q != H_IDLE)
        sck_q <= ~sck_q;
      case (st_q)
        H_IDLE:
          if (i_start)
          begin
            st_q <= H_OPC;
            cnt_q <= 6'h0;
            oe_n_q <= 4'hE;
            case (i_cmd)
              MIOR_CMD_QIO:
              begin
                sh_q <= {MIOR_OP_QUAD_IO, i_addr}; // see RL1
                aw_q <= 2'h2;
                dw_q <= 2'h2;
                mode_q <= MIOR_QIO_MODE; // see RL2
                dummy_q <= MIOR_QIO_DUMMY;
              end
              MIOR_CMD_QOUT:
              begin
                sh_q <= {MIOR_OP_QUAD_OUT, i_addr}; // see RL3
                aw_q <= 2'h0;
                dw_q <= 2'h2;
                mode_q <= MIOR_QOUT_MODE; // see RL4
                dummy_q <= MIOR_QOUT_DUMMY;
              end
              MIOR_CMD_DOUT:
              begin
                sh_q <= {MIOR_OP_DUAL_OUT, i_addr}; // see RL5
                aw_q <= 2'h0;
                dw_q <= 2'h1;
                mode_q <= MIOR_DOUT_MODE; // see RL6
                dummy_q <= MIOR_DOUT_DUMMY;
              end
              default:
              begin
                sh_q <= {MIOR_OP_DUAL_IO, i_addr}; // see RL7
                aw_q <= 2'h1;
                dw_q <= 2'h1;
                mode_q <= i_enh_lat ? MIOR_DIO_MODE_ENH : MIOR_DIO_MODE_STD; // see RL8
                dummy_q <= i_enh_lat ? MIOR_DIO_DUMMY_ENH : MIOR_DIO_DUMMY_STD;
              end
            endcase
          end
        default:
          if (sck_q)
          begin
            cnt_q <= cnt_q + 6'h1;
            if (st_q == H_OPC)
            begin
              sh_q <= {sh_q[30:0], 1'b0};
              if (cnt_q == 6'h7)
              begin
                cnt_q <= 6'h0;
                st_q <= H_ADDR;
                oe_n_q <= (aw_q == 2'h2) ? 4'h0 : (aw_q == 2'h1) ? 4'hC : 4'hE;
              end
            end
            else if (st_q == H_ADDR)
            begin
              sh_q <= (aw_q == 2'h2) ? {sh_q[27:0], 4'h0} :
                      (aw_q == 2'h1) ? {sh_q[29:0], 2'h0} : {sh_q[30:0], 1'b0};
              if (cnt_q == ((aw_q == 2'h2) ? 6'd5 : (aw_q == 2'h1) ? 6'd11 : 6'd23))
              begin
                cnt_q <= 6'h0;
                sh_q <= 32'h0;
                st_q <= (mode_q != 3'h0) ? H_MODE : (dummy_q != 5'h0) ? H_DUMMY : H_DATA;
                if (mode_q == 3'h0)
                  oe_n_q <= 4'hF; // see RL12
              end
            end
            else if (st_q == H_MODE)
            begin
              if (cnt_q == {3'h0, mode_q} - 6'h1)
              begin
                cnt_q <= 6'h0;
                oe_n_q <= 4'hF; // see RL12
                st_q <= (dummy_q != 5'h0) ? H_DUMMY : H_DATA;
              end
            end
            else if (st_q == H_DUMMY)
            begin
              if (cnt_q == {1'h0, dummy_q} - 6'h1)
              begin
                cnt_q <= 6'h0;
                st_q <= H_DATA;
              end
            end
            else
            begin
              rx_q <= (dw_q == 2'h2) ? {rx_q[3:0], bus.io_in} : {rx_q[5:0], bus.io_in[1:0]};
              if (cnt_q == ((dw_q == 2'h2) ? 6'd1 : 6'd3))
              begin
                cnt_q <= 6'h0;
                o_data <= (dw_q == 2'h2) ? {rx_q[3:0], bus.io_in} :
                          {rx_q[5:0], bus.io_in[1:0]};
                o_data_valid <= 1'b1;
                if (i_stop)
                begin
                  st_q <= H_IDLE;
                  sck_q <= 1'b0;
                end
              end
            end
          end
      endcase
    end
  end

endmodule

// file: sim/mior_assertions.sv
// Checker for the multi-I/O read wire: opcode framing and line ownership per phase.
// Assumes instantiation beside the interface, its signals connected by name.
`timescale 1ns/100ps
module mior_assertions (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_io_out,
  input wire logic [3:0] h_io_oe_n,
  input wire logic [3:0] d_io_out,
  input wire logic [3:0] d_io_oe_n,
  input wire logic [3:0] io_in
);
  logic sck_q;
  logic [5:0] cnt_q;
  logic [7:0] op_q;
  logic hi;
  logic qo;
  // Bit n+1 of the frame is on the lines while SCK is high and cnt_q is n
  assign hi = !cs_n && sck;
  assign qo = (op_q == 8'h6B) || (op_q == 8'h3B);
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || cs_n)
      cnt_q <= 6'h00;
    else if (sck && !sck_q && cnt_q != 6'h3F)
      cnt_q <= cnt_q + 6'h01;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (!cs_n && sck && !sck_q && cnt_q < 6'h08)
      op_q <= {op_q[6:0], io_in[0]};
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_no_contention: assert property ((h_io_oe_n | d_io_oe_n) == 4'hF)
    else $error("both ends drive a line");
  a_dev_idle_release: assert property (cs_n [*8] |-> d_io_oe_n == 4'hF)
    else $error("device drives while deselected");
  a_opcode_on_io0: assert property (hi && cnt_q < 6'h08 |-> !h_io_oe_n[0])
    else $error("opcode not driven on io0");
  a_opcode_legal: assert property ($rose(cnt_q == 6'h08) |->
    op_q inside {8'hEB, 8'h6B, 8'h3B, 8'hBB})
    else $error("illegal opcode on wire");
  a_qio_addr_quad: assert property (hi && op_q == 8'hEB &&
    cnt_q inside {[6'h08:6'h0D]} |-> h_io_oe_n == 4'h0)
    else $error("quad io address not on four lines");
  a_qio_mode_two: assert property (hi && op_q == 8'hEB &&
    cnt_q inside {[6'h0E:6'h0F]} |-> h_io_oe_n == 4'h0 && h_io_out == 4'h0)
    else $error("quad io mode cycles wrong");
  a_qio_dummy_four: assert property (hi && op_q == 8'hEB &&
    cnt_q inside {[6'h10:6'h13]} |-> h_io_oe_n == 4'hF)
    else $error("host drives in quad io dummy");
  a_single_addr: assert property (hi && qo &&
    cnt_q inside {[6'h08:6'h1F]} |-> !h_io_oe_n[0])
    else $error("single line address missing");
  a_out_dummy_eight: assert property (hi && qo &&
    cnt_q inside {[6'h20:6'h27]} |-> h_io_oe_n == 4'hF)
    else $error("host drives in output dummy");
  a_dio_addr_dual: assert property (hi && op_q == 8'hBB &&
    cnt_q inside {[6'h08:6'h13]} |-> h_io_oe_n[1:0] == 2'h0)
    else $error("dual io address not on two lines");
  c_qio: cover property ($rose(cnt_q == 6'h08) && op_q == 8'hEB);
  c_qout: cover property ($rose(cnt_q == 6'h08) && op_q == 8'h6B);
  c_dout: cover property ($rose(cnt_q == 6'h08) && op_q == 8'h3B);
  c_dio: cover property ($rose(cnt_q == 6'h08) && op_q == 8'hBB);
endmodule

// file: sim/testbench.sv
// Testbench joining host and device ends across the interface, with a wire monitor.
// Assumes released lines float: they show a pattern that changes every cycle.
`timescale 1ns/100ps
module testbench;
  import mior_pkg::*;
  logic sys_clk, sys_rst, start, enh_lat, stop, ready, data_valid, addr_valid, busy;
  logic sck_p, disc_req, first;
  mior_cmd_t cmd;
  logic [23:0] addr, dev_addr;
  logic [7:0] rd_data, disc_ofs, disc_byte, data, mon_op;
  logic [3:0] float_q;
  int err_total, check_count, seed, mon_cnt;
  logic [7:0] exp_data[$], exp_op[$], exp_disc[$];
  logic [23:0] exp_addr[$];
  int exp_rise[$];
  mior_if bus_if();
  mior_host i_mior_host (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .bus(bus_if.host),
    .i_start(start), .i_cmd(cmd), .i_enh_lat(enh_lat), .i_addr(addr), .i_stop(stop),
    .o_ready(ready), .o_data(data), .o_data_valid(data_valid));
  mior_dev i_mior_dev (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .bus(bus_if.dev),
    .i_enh_lat(enh_lat), .i_rd_data(rd_data), .i_disc_ofs(disc_ofs), .o_disc_byte(disc_byte),
    .o_busy(busy), .o_addr(dev_addr), .o_addr_valid(addr_valid));
  mior_assertions i_mior_assertions (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
    .sck(bus_if.sck), .cs_n(bus_if.cs_n), .h_io_out(bus_if.h_io_out),
    .h_io_oe_n(bus_if.h_io_oe_n), .d_io_out(bus_if.d_io_out),
    .d_io_oe_n(bus_if.d_io_oe_n), .io_in(bus_if.io_in));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) float_q <= ~float_q;
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      if (!bus_if.h_io_oe_n[k])
        bus_if.io_in[k] = bus_if.h_io_out[k];
      else if (!bus_if.d_io_oe_n[k])
        bus_if.io_in[k] = bus_if.d_io_out[k];
      else
        bus_if.io_in[k] = float_q[k];
  end
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail(input string msg);
    err_total++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic chk_byte(input logic [7:0] got, ref logic [7:0] q[$], input string what);
    check_count++;
    if (q.size() == 0)
      fail({"unexpected ", what});
    else if (got !== q.pop_front())
      fail({"wrong ", what});
  endtask
  task automatic chk_addr(input logic [23:0] got, ref logic [23:0] q[$]);
    check_count++;
    if (q.size() == 0 || got !== q.pop_front())
      fail("wrong address");
  endtask
  task automatic chk_flag(input logic got, input logic want, input string what);
    check_count++;
    if (got !== want)
      fail({"wrong ", what});
  endtask
  task automatic chk_cnt(input int got, ref int q[$]);
    check_count++;
    if (q.size() == 0 || got != q.pop_front())
      fail("wrong clock count to data");
  endtask
  // Wire and output monitor
  always @(posedge sys_clk)
  begin
    // Byte checks first: the last byte of a read lands as cs_n rises
    if (data_valid === 1'b1)
    begin
      if (first)
        chk_cnt(mon_cnt, exp_rise);
      first = 1'b0;
      chk_byte(data, exp_data, "data");
    end
    if (sys_rst || bus_if.cs_n)
    begin
      mon_cnt = 0;
      first = 1'b1;
    end
    else if (bus_if.sck && !sck_p)
    begin
      if (mon_cnt < 8)
        mon_op = {mon_op[6:0], bus_if.io_in[0]};
      mon_cnt++;
      if (mon_cnt == 8)
        chk_byte(mon_op, exp_op, "opcode");
    end
    sck_p = bus_if.sck;
    if (addr_valid === 1'b1)
    begin
      chk_addr(dev_addr, exp_addr);
      chk_flag(busy, 1'b1, "busy in frame");
    end
    if (disc_req)
      chk_byte(disc_byte, exp_disc, "discovery byte");
  end
  function automatic logic [7:0] disc_exp(input logic [7:0] o, input logic e);
    case (o)
      8'h08: disc_exp = 8'h44;
      8'h09: disc_exp = 8'hEB;
      8'h0A: disc_exp = 8'h08;
      8'h0B: disc_exp = 8'h6B;
      8'h0C: disc_exp = 8'h08;
      8'h0D: disc_exp = 8'h3B;
      8'h0E: disc_exp = e ? 8'h80 : 8'h04;
      8'h0F: disc_exp = 8'hBB;
      default: disc_exp = 8'hFF;
    endcase
  endfunction
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (ready !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000)
    begin
      fail("timeout");
      wrap_up();
    end
  endtask
  task automatic do_read(input mior_cmd_t c, input logic e, input int nb);
    int n, ln, al, md, dm;
    logic [7:0] op;
    wait_ready();
    // Deselect gap so the device sees cs_n high and lets go of the lines
    repeat (4) @(posedge sys_clk);
    chk_flag(busy, 1'b0, "busy when deselected");
    #1;
    cmd = c;
    enh_lat = e;
    addr = 24'($random(seed));
    rd_data = 8'($random(seed));
    stop = (nb == 1);
    start = 1'b1;
    case (c)
      MIOR_CMD_QIO: {op, ln, al, md, dm} = {8'hEB, 32'd4, 32'd4, 32'd2, 32'd4};
      MIOR_CMD_QOUT: {op, ln, al, md, dm} = {8'h6B, 32'd4, 32'd1, 32'd0, 32'd8};
      MIOR_CMD_DOUT: {op, ln, al, md, dm} = {8'h3B, 32'd2, 32'd1, 32'd0, 32'd8};
      default: {op, ln, al, md, dm} = {8'hBB, 32'd2, 32'd2, e ? 32'd4 : 32'd0, e ? 32'd0 : 32'd4};
    endcase
    exp_op.push_back(op);
    exp_addr.push_back(addr);
    exp_rise.push_back(8 + 24 / al + md + dm + 8 / ln);
    repeat (nb) exp_data.push_back(rd_data);
    @(posedge sys_clk);
    #1 start = 1'b0;
    n = 0;
    while (nb > 1 && n < 3000)
    begin
      @(posedge sys_clk);
      n = (data_valid === 1'b1) ? 3001 : n + 1;
    end
    if (n == 3000)
    begin
      fail("timeout");
      wrap_up();
    end
    #1 stop = 1'b1;
  endtask
  initial
  begin
    {sys_clk, start, enh_lat, addr, rd_data, disc_ofs, disc_req, sck_p, mon_op} = '0;
    {sys_rst, stop, first} = 3'h7;
    cmd = MIOR_CMD_QIO;
    float_q = 4'h5;
    {err_total, check_count, mon_cnt} = '0;
    seed = 79;
    repeat (8) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 9; i++)
      begin
        @(posedge sys_clk);
        #1;
        enh_lat = e[0];
        disc_ofs = (i == 8) ? 8'hFF : 8'(8 + i);
        disc_req = 1'b1;
        exp_disc.push_back(disc_exp(disc_ofs, enh_lat));
      end
    @(posedge sys_clk);
    #1 disc_req = 1'b0;
    $display("Test discovery table done");
    for (int i = 0; i < 5; i++)
      do_read(mior_cmd_t'(i < 4 ? i : 3), i == 4, i % 2 + 1);
    $display("Test each read command done");
    repeat (8) do_read(mior_cmd_t'(2'($random(seed))), 1'($random(seed)), 1 + (i_bit()));
    wait_ready();
    repeat (10) @(posedge sys_clk);
    if (exp_data.size() + exp_addr.size() + exp_op.size() + exp_rise.size() != 0)
      fail("results missing");
    $display("Test random reads done");
    wrap_up();
  end
  function automatic int i_bit();
    i_bit = $random(seed) & 1;
  endfunction
endmodule
